// [rtl/pmt_pkg.sv]
package pmt_pkg;
    // register byte addresses on the bus
    localparam logic [7:0] PMT_OFF_COUNT  = 8'h00;
    localparam logic [7:0] PMT_OFF_PERIOD = 8'h04;
    localparam logic [7:0] PMT_OFF_CTRL   = 8'h08;
    localparam logic [7:0] PMT_OFF_FLAGS  = 8'h0C;
    localparam logic [7:0] PMT_OFF_ENABLE = 8'h10;
    // control field positions
    localparam int PMT_CTRL_PRE_LSB  = 0;
    localparam int PMT_CTRL_RUN_BIT  = 2;
    localparam int PMT_CTRL_POST_LSB = 3;
    // flag and enable bit position
    localparam int PMT_IRQ_MATCH_BIT = 0;
    // values after reset
    localparam logic [7:0] PMT_COUNT_RST  = 8'h00;
    localparam logic [7:0] PMT_PERIOD_RST = 8'hFF;
    localparam logic [6:0] PMT_CTRL_RST   = 7'h00;
    // instruction clock is one quarter of the oscillator
    localparam int PMT_OSC_PER_INSTR = 4;
    localparam logic [1:0] PMT_INSTR_LAST = 2'(PMT_OSC_PER_INSTR - 1);
endpackage : pmt_pkg

// [rtl/pmt_timer.sv]
// How it works
// R1: the timer ticks on the instruction clock, one quarter of clk.
// R2: count and period registers are eight bits wide.
// R3: the count rises from zero by one on each prescaled tick.
// R4: a six-bit prescaler divides by 1, 4 or 16 (code 3 gives 64).
// R5: count equal to period makes the match output.
// R6: a match loads zero into the count on the next tick.
// R7: software reads and writes both count and period.
// R8: reset clears the count and sets the period to all ones.
// R9: count or control writes and any reset clear both scalers.
// R10: a four-bit postscaler counts matches and sets the latched flag.
// R11: the flag raises the interrupt only when its enable is set.
// R12: control bits 6..3 pick a postscale of 1:(n+1).
// R13: the unscaled match goes out to the capture/compare/pwm unit.
// R14: the match is offered as the serial port shift clock.
// R15: in sleep the timer stops and keeps its registers.
// R16: the count advances only while the run enable bit is set.
// R17: the flag stays set until cleared by reading the flag register.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
module pmt_timer
    import pmt_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        reset_n_in,
    input  wire logic        sleep_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             irq_out,
    output logic             pwm_timebase_out,
    output logic             spi_shift_clk_out
);

    typedef struct packed {
        logic [1:0]  quarter;
        // R2: eight-bit count and period
        logic [7:0]  count_reg;
        logic [7:0]  period_reg;
        logic [6:0]  ctrl_reg;
        logic [3:0]  pre_reg;
        logic [1:0]  pre_hi_reg;
        logic [3:0]  post_reg;
        logic        match_pend;
        logic        flag_reg;
        logic        enable_reg;
        logic [31:0] rdata_reg;
        logic        ready_reg;
        logic        err_reg;
        logic        irq_reg;
        logic        match_reg;
    } pmt_state_t;

    pmt_state_t st_reg;
    pmt_state_t st_next;

    logic       instr_tick;
    logic       pre_tick;
    logic       match;
    logic       wr_acc;
    logic       rd_acc;
    logic       known;
    logic       set_flag;
    logic [1:0] pre_sel;
    logic [3:0] post_sel;
    logic       run_en;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        pre_sel  = st_reg.ctrl_reg[PMT_CTRL_PRE_LSB +: 2];
        // R12: postscale field, n+1 matches
        post_sel = st_reg.ctrl_reg[PMT_CTRL_POST_LSB +: 4];
        run_en   = st_reg.ctrl_reg[PMT_CTRL_RUN_BIT];
        // R1: quarter-rate tick
        instr_tick = (st_reg.quarter == PMT_INSTR_LAST) && !sleep_in;
        // R4: prescaler taps
        unique case (pre_sel)
            2'h0: pre_tick = instr_tick;
            2'h1: pre_tick = instr_tick && (st_reg.pre_reg[1:0] == 2'h3);
            2'h2: pre_tick = instr_tick && (st_reg.pre_reg == 4'hF);
            2'h3: pre_tick = instr_tick && (st_reg.pre_reg == 4'hF)
                             && (st_reg.pre_hi_reg == 2'h3);
        endcase
        // R5: comparator
        match  = (st_reg.count_reg == st_reg.period_reg);
        wr_acc = psel_in && penable_in && pwrite_in && st_reg.ready_reg;
        rd_acc = psel_in && penable_in && !pwrite_in && st_reg.ready_reg;
        known  = (paddr_in == PMT_OFF_COUNT) || (paddr_in == PMT_OFF_PERIOD)
              || (paddr_in == PMT_OFF_CTRL) || (paddr_in == PMT_OFF_FLAGS)
              || (paddr_in == PMT_OFF_ENABLE);
        set_flag = 1'b0;
        st_next = st_reg;

        // R15: sleep freezes the quarter divider and so the count; the bus port still runs
        if (!sleep_in) begin
            st_next.quarter = st_reg.quarter + 2'h1;
        end
        if (instr_tick && run_en) begin
            {st_next.pre_hi_reg, st_next.pre_reg} =
                {st_reg.pre_hi_reg, st_reg.pre_reg} + 6'h01;
        end
        // R16: run enable gates counting
        if (pre_tick && run_en) begin
            st_next.match_pend = 1'b0;
            // R6: reload after match
            if (match) begin
                st_next.count_reg = PMT_COUNT_RST;
                // R10: postscaler on matches
                if (st_reg.post_reg == post_sel) begin
                    st_next.post_reg = 4'h0;
                    set_flag = 1'b1;
                end else begin
                    st_next.post_reg = st_reg.post_reg + 4'h1;
                end
            end else begin
                // R3: increment
                st_next.count_reg = st_reg.count_reg + 8'h01;
            end
        end
        // R13: unscaled match out, one per tick
        st_next.match_reg = match && pre_tick && run_en;

        // bus access: one wait state, ready on the second access cycle
        st_next.ready_reg = psel_in && penable_in && !st_reg.ready_reg;
        st_next.err_reg   = psel_in && penable_in && !st_reg.ready_reg
                            && !known;
        if (wr_acc) begin
            // R7: software writes
            unique case (paddr_in)
                PMT_OFF_COUNT: begin
                    st_next.count_reg = pwdata_in[7:0];
                    // R9: scalers cleared on count write
                    st_next.pre_reg    = 4'h0;
                    st_next.pre_hi_reg = 2'h0;
                    st_next.post_reg   = 4'h0;
                end
                PMT_OFF_PERIOD: st_next.period_reg = pwdata_in[7:0];
                PMT_OFF_CTRL: begin
                    st_next.ctrl_reg   = pwdata_in[6:0];
                    // R9: scalers cleared on control write
                    st_next.pre_reg    = 4'h0;
                    st_next.pre_hi_reg = 2'h0;
                    st_next.post_reg   = 4'h0;
                end
                PMT_OFF_ENABLE:
                    st_next.enable_reg = pwdata_in[PMT_IRQ_MATCH_BIT];
                default: ;
            endcase
        end
        st_next.rdata_reg = 32'h0000_0000;
        if (st_next.ready_reg && !pwrite_in) begin
            unique case (paddr_in)
                PMT_OFF_COUNT:  st_next.rdata_reg[7:0] = st_reg.count_reg;
                PMT_OFF_PERIOD: st_next.rdata_reg[7:0] = st_reg.period_reg;
                PMT_OFF_CTRL:   st_next.rdata_reg[6:0] = st_reg.ctrl_reg;
                PMT_OFF_FLAGS:
                    st_next.rdata_reg[PMT_IRQ_MATCH_BIT] = st_reg.flag_reg;
                PMT_OFF_ENABLE:
                    st_next.rdata_reg[PMT_IRQ_MATCH_BIT] = st_reg.enable_reg;
                default: ;
            endcase
        end
        // R17: read clears, a flag set by the postscaler in the same cycle wins
        if (rd_acc && paddr_in == PMT_OFF_FLAGS) begin
            st_next.flag_reg = 1'b0;
        end
        if (set_flag) begin
            st_next.flag_reg = 1'b1;
        end
        // R11: gated interrupt
        st_next.irq_reg = st_next.flag_reg && st_next.enable_reg;
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            // R8: reset values, R9: scalers cleared
            st_reg            <= '0;
            st_reg.count_reg  <= PMT_COUNT_RST;
            st_reg.period_reg <= PMT_PERIOD_RST;
            st_reg.ctrl_reg   <= PMT_CTRL_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata_out        = st_reg.rdata_reg;
    assign pready_out        = st_reg.ready_reg;
    assign pslverr_out       = st_reg.err_reg;
    assign irq_out           = st_reg.irq_reg;
    // R14: shift clock source
    assign spi_shift_clk_out = st_reg.match_reg;
    assign pwm_timebase_out  = st_reg.match_reg;

    ////////////////////////////////////////////////////////////////////
    property p_reload;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (match && pre_tick && run_en && !wr_acc)
            |=> (st_reg.count_reg == 8'h00);
    endproperty
    a_reload: assert property (p_reload) // R6
        else $error("count not reloaded after match");

    property p_hold;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (!run_en && !wr_acc) |=> $stable(st_reg.count_reg);
    endproperty
    a_hold: assert property (p_hold) // R16
        else $error("count moved while stopped");

    property p_sleep;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (sleep_in && !wr_acc) |=> $stable(st_reg.count_reg)
            && $stable(st_reg.period_reg);
    endproperty
    a_sleep: assert property (p_sleep) // R15
        else $error("registers changed in sleep");

    property p_tick;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        instr_tick |=> !instr_tick [*3];
    endproperty
    a_tick: assert property (p_tick) // R1
        else $error("instruction tick too frequent");

    property p_irq;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        irq_out == (st_reg.flag_reg && st_reg.enable_reg);
    endproperty
    a_irq: assert property (p_irq) // R11
        else $error("interrupt not gated by enable");

    property p_flag_set;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        set_flag |=> st_reg.flag_reg && (irq_out == st_reg.enable_reg);
    endproperty
    a_flag_set: assert property (p_flag_set) // R10
        else $error("flag not set on postscale");

    property p_scaler_clr;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (wr_acc && (paddr_in == PMT_OFF_COUNT || paddr_in == PMT_OFF_CTRL))
            |=> (st_reg.pre_reg == 4'h0) && (st_reg.post_reg == 4'h0);
    endproperty
    a_scaler_clr: assert property (p_scaler_clr) // R9
        else $error("scalers not cleared by write");

    property p_match_out;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        pwm_timebase_out |-> $past(match && pre_tick && run_en);
    endproperty
    a_match_out: assert property (p_match_out) // R13
        else $error("time base pulse without match");

    property p_timebase_pulse;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        pwm_timebase_out |=> !pwm_timebase_out;
    endproperty
    a_timebase_pulse: assert property (p_timebase_pulse) // R13
        else $error("time base pulse longer than one cycle");

    property p_shift_same;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        spi_shift_clk_out == pwm_timebase_out;
    endproperty
    a_shift_same: assert property (p_shift_same) // R14
        else $error("shift clock differs from time base");

    property p_count_inc;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (pre_tick && run_en && !match && !wr_acc)
            |=> (st_reg.count_reg == $past(st_reg.count_reg) + 8'h01);
    endproperty
    a_count_inc: assert property (p_count_inc) // R3
        else $error("count did not step by one");

    property p_sleep_quarter;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        sleep_in |=> $stable(st_reg.quarter);
    endproperty
    a_sleep_quarter: assert property (p_sleep_quarter) // R15
        else $error("instruction divider ran in sleep");

    property p_period_write;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (wr_acc && paddr_in == PMT_OFF_PERIOD)
            |=> (st_reg.period_reg == $past(pwdata_in[7:0]));
    endproperty
    a_period_write: assert property (p_period_write) // R7
        else $error("period write lost");

    property p_ctrl_write;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (wr_acc && paddr_in == PMT_OFF_CTRL)
            |=> (st_reg.ctrl_reg == $past(pwdata_in[6:0]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) // R12
        else $error("control write lost");

    property p_flag_clear;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (rd_acc && paddr_in == PMT_OFF_FLAGS && !set_flag)
            |=> !st_reg.flag_reg;
    endproperty
    a_flag_clear: assert property (p_flag_clear) // R17
        else $error("flag not cleared by read");

    property p_flag_sticky;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (st_reg.flag_reg && !(rd_acc && paddr_in == PMT_OFF_FLAGS))
            |=> st_reg.flag_reg;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // R17
        else $error("flag dropped without a read");

    property p_irq_masked;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        !st_reg.enable_reg |-> !irq_out;
    endproperty
    a_irq_masked: assert property (p_irq_masked) // R11
        else $error("interrupt raised while masked");

    property p_ready_pulse;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        pready_out |=> !pready_out;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) // R7
        else $error("ready held longer than one cycle");

    property p_ready_wait;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (psel_in && penable_in && !pready_out) |=> pready_out;
    endproperty
    a_ready_wait: assert property (p_ready_wait) // R7
        else $error("ready not given after one wait state");

    property p_err_unmapped;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (psel_in && penable_in && !pready_out && !known) |=> pslverr_out;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) // R7
        else $error("unmapped access without error");

    property p_err_ready;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        pslverr_out |-> pready_out;
    endproperty
    a_err_ready: assert property (p_err_ready) // R7
        else $error("error outside the ready cycle");

    property p_rdata_idle;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        !pready_out |-> (prdata_out == 32'h0000_0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) // R7
        else $error("read data outside the ready cycle");

endmodule : pmt_timer

// [verif/pmt_timer_tb_top.sv]
`timescale 1ns/1ps
module pmt_timer_tb_top;
    import pmt_pkg::*;
    logic        clk_sys_in, reset_n_in, sleep_in, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata_out;
    logic        pready_out, pslverr_out, irq_out, pwm_out, spi_out;
    int          mismatches, checked;
    pmt_timer pmt_timer_i (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .sleep_in(sleep_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .irq_out(irq_out),
        .pwm_timebase_out(pwm_out), .spi_shift_clk_out(spi_out));
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    ////////////////////////////////////////////////////////////////////
    task test_done;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task hang(input string nm);
        mismatches++;
        $display("MISMATCH %s expected answer seen timeout", nm);
        test_done();
    endtask : hang
    // one access: setup, access until pready, release
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_sys_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        n = 0;
        // ready sampled at the rising edge, data taken there too
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n >= 20) hang("pready");
        rd = prdata_out;
        err = pslverr_out;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] r, output logic e);
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd
    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        rd(a, r, e);
        chk(nm, x, r);
        chk("pslverr", 32'h0, {31'h0, e});
    endtask : rdchk
    // cycles from here to the next timebase pulse
    task wait_tb(output int c);
        c = 0;
        do begin
            @(negedge clk_sys_in);
            c++;
        end while (pwm_out !== 1'b1 && c < 2000);
        if (c >= 2000) hang("timebase");
        chk("shift clk", {31'h0, pwm_out}, {31'h0, spi_out});
    endtask : wait_tb
    ////////////////////////////////////////////////////////////////////
    task t_reset;
        logic [31:0] r;
        logic        e;
        rdchk("count", PMT_OFF_COUNT, 32'h00);
        rdchk("period", PMT_OFF_PERIOD, 32'hFF);
        rdchk("ctrl", PMT_OFF_CTRL, 32'h00);
        rdchk("flags", PMT_OFF_FLAGS, 32'h00);
        wr(8'h20, 32'hFF);
        rd(8'h20, r, e);
        chk("unmapped", 32'h0000_0001, {r[30:0], e});
        $display("test reset done");
    endtask : t_reset
    task t_regs;
        wr(PMT_OFF_COUNT, 32'h1FF);
        wr(PMT_OFF_PERIOD, 32'hF5A);
        rdchk("count", PMT_OFF_COUNT, 32'hFF);
        rdchk("period", PMT_OFF_PERIOD, 32'h5A);
        wr(PMT_OFF_CTRL, 32'hFB);
        rdchk("ctrl", PMT_OFF_CTRL, 32'h7B);
        repeat (40) @(posedge clk_sys_in);
        rdchk("held", PMT_OFF_COUNT, 32'hFF);
        $display("test registers done");
    endtask : t_regs
    task t_period;
        int c;
        wr(PMT_OFF_PERIOD, 32'h02);
        for (int k = 0; k < 4; k++) begin
            wr(PMT_OFF_CTRL, 32'(k) | 32'h04);
            wait_tb(c);
            wait_tb(c);
            chk("interval", 32'(12 << (2 * k)), 32'(c));
        end
        $display("test period done");
    endtask : t_period
    task t_post;
        int          c, p;
        logic [31:0] r;
        logic        e;
        wr(PMT_OFF_ENABLE, 32'h01);
        wr(PMT_OFF_CTRL, 32'h14);
        rd(PMT_OFF_FLAGS, r, e);
        // let the read clear settle before watching irq
        @(negedge clk_sys_in);
        c = 0;
        p = 0;
        while (irq_out !== 1'b1 && c < 200) begin
            @(negedge clk_sys_in);
            c++;
            if (pwm_out === 1'b1) p++;
        end
        if (c >= 200) hang("irq");
        chk("matches per flag", 32'd3, 32'(p));
        rdchk("flags", PMT_OFF_FLAGS, 32'h01);
        repeat (2) @(negedge clk_sys_in);
        chk("irq cleared", 32'h0, {31'h0, irq_out});
        wr(PMT_OFF_ENABLE, 32'h00);
        repeat (60) @(negedge clk_sys_in);
        chk("irq masked", 32'h0, {31'h0, irq_out});
        rdchk("flags", PMT_OFF_FLAGS, 32'h01);
        $display("test postscale done");
    endtask : t_post
    task t_sleep;
        logic [31:0] a, b;
        logic        e;
        wr(PMT_OFF_PERIOD, 32'hFF);
        wr(PMT_OFF_CTRL, 32'h04);
        wr(PMT_OFF_COUNT, 32'h00);
        rd(PMT_OFF_COUNT, a, e);
        repeat (40) @(posedge clk_sys_in);
        rd(PMT_OFF_COUNT, b, e);
        chk("advance", 32'h1, {31'h0, (b - a) inside {[9:12]}});
        sleep_in <= 1'b1;
        rd(PMT_OFF_COUNT, a, e);
        repeat (40) @(posedge clk_sys_in);
        rdchk("sleep count", PMT_OFF_COUNT, a);
        rdchk("sleep period", PMT_OFF_PERIOD, 32'hFF);
        sleep_in <= 1'b0;
        $display("test sleep done");
    endtask : t_sleep
    ////////////////////////////////////////////////////////////////////
    initial begin
        mismatches = 0;
        checked = 0;
        reset_n_in = 1'b0;
        sleep_in = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        t_reset();
        t_regs();
        t_period();
        t_post();
        t_sleep();
        test_done();
    end
endmodule : pmt_timer_tb_top
